/* File: srtx_defines.vh */
`ifndef SRTX_DEFINES_VH
`define SRTX_DEFINES_VH
// Serial frame layout: start, data bits, id bit, stop.
`define SRTX_DATA_BITS     8
`define SRTX_BIT_CYCLES    16'h0010
// Reset values of the control bits.
`define SRTX_GATE_RESET    1'b0
`define SRTX_RX_EN_RESET   1'b0
`define SRTX_TX_EN_RESET   1'b0
// Receiver and transmitter states.
`define SRTX_ST_IDLE       2'h0
`define SRTX_ST_START      2'h1
`define SRTX_ST_DATA       2'h2
`define SRTX_ST_STOP       2'h3
`endif

/* File: srtx_station.sv */
`timescale 1ns/1ps
// Far station: drives frames on the shared line, idle high between them.
module srtx_station
#(
   parameter BC = 4
)
(
   input  wire clk,
   output reg  line
);
   initial line = 1'b1;
   // Sends start, data LSB first, id bit and a stop bit that may be bad on purpose.
   task send(input [7:0] d, input id, input stp);
      integer    k;
      reg [10:0] f;
      begin
         f = {stp, id, d, 1'b0};
         for (k = 0; k < 11; k = k + 1)
         begin
            @(negedge clk) line = f[k];
            repeat (BC - 1) @(negedge clk);
         end
         @(negedge clk) line = 1'b1;
         repeat (3 * BC) @(negedge clk);
      end
   endtask
endmodule

/* File: srtx_top.v */
`timescale 1ns/1ps
`include "srtx_defines.vh"

// How it works
// - Gate bit 0: frames update flags and raise requests normally.
// - A received frame with id bit 1 clears the gate bit automatically.
// - Software writing gate bit 0 ends filtering at once.
// - Gate bit 1: no new full or error request until an id-bit-1 frame.
// - Gate bit 1: full, framing and overrun flags stay unset by id-bit-0 frames.
// - Receive enable 0 stops the receiver; 1 lets frames in.
module srtx_top
#(
   parameter DW      = `SRTX_DATA_BITS,
   parameter [15:0] BIT_CYC = `SRTX_BIT_CYCLES
)
(
   // Clock and reset.
   input  wire          clk,
   input  wire          rstn,
   // Control bits from software.
   input  wire          gate_wr,
   input  wire          gate_wdata,
   input  wire          rx_en,
   input  wire          tx_en,
   // Flag clears from software.
   input  wire          rx_full_clr,
   input  wire          err_clr,
   // Receive side.
   input  wire          rxd,
   output reg  [DW-1:0] rx_data,
   output reg           rx_id_bit,
   output wire          mp_gate_enable,
   output reg           rx_full_flag,
   output reg           framing_err_flag,
   output reg           overrun_flag,
   output wire          rx_full_irq,
   output wire          rx_error_irq,
   // Transmit side.
   input  wire          tx_valid,
   input  wire [DW-1:0] tx_data,
   input  wire          frame_id_bit,
   output wire          tx_ready,
   output wire          tx_end_irq,
   output wire          txd
);

   reg          gate_q;
   reg          rxd_s1_q;
   reg          rxd_q;
   reg  [1:0]   st_q;
   reg  [15:0]  cnt_q;
   reg  [3:0]   bit_q;
   reg  [DW:0]  sh_q;
   reg          done_q;
   reg          stop_ok_q;
   wire         pass;

   assign mp_gate_enable = gate_q;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser for the receive pin.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rxd_s1_q <= 1'b1;
         rxd_q    <= 1'b1;
      end
      else
      begin
         rxd_s1_q <= rxd;
         rxd_q    <= rxd_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver: samples mid-bit, collects data, id bit and stop bit.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q      <= `SRTX_ST_IDLE;
         cnt_q     <= 16'h0000;
         bit_q     <= 4'h0;
         sh_q      <= {(DW+1){1'b0}};
         done_q    <= 1'b0;
         stop_ok_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (!rx_en)
         begin
            st_q <= `SRTX_ST_IDLE;
         end
         else
         begin
            case (st_q)
               `SRTX_ST_IDLE:
               begin
                  cnt_q <= 16'h0000;
                  if (!rxd_q)
                  begin
                     st_q <= `SRTX_ST_START;
                  end
               end
               `SRTX_ST_START:
               begin
                  if (cnt_q == (BIT_CYC >> 1) - 16'h0001)
                  begin
                     cnt_q <= 16'h0000;
                     bit_q <= 4'h0;
                     st_q  <= rxd_q ? `SRTX_ST_IDLE : `SRTX_ST_DATA;
                  end
                  else
                  begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
               `SRTX_ST_DATA:
               begin
                  if (cnt_q == BIT_CYC - 16'h0001)
                  begin
                     cnt_q <= 16'h0000;
                     sh_q  <= {rxd_q, sh_q[DW:1]};
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == DW)
                     begin
                        st_q <= `SRTX_ST_STOP;
                     end
                  end
                  else
                  begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
               `SRTX_ST_STOP:
               begin
                  if (cnt_q == BIT_CYC - 16'h0001)
                  begin
                     stop_ok_q <= rxd_q;
                     done_q    <= 1'b1;
                     st_q      <= `SRTX_ST_IDLE;
                  end
                  else
                  begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
               default:
               begin
                  st_q <= `SRTX_ST_IDLE;
               end
            endcase
         end
      end
   end

   // A frame reaches the flags if the gate is off or it carries id bit 1.
   assign pass = done_q && (!gate_q || sh_q[DW]);

   ////////////////////////////////////////////////////////////////////////////
   // Gate bit: software sets or clears; an id-bit-1 frame clears it.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         gate_q <= `SRTX_GATE_RESET;
      end
      else if (done_q && sh_q[DW])
      begin
         gate_q <= 1'b0;
      end
      else if (gate_wr)
      begin
         gate_q <= gate_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags and received data; a set wins over a same-cycle clear.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_full_flag     <= 1'b0;
         framing_err_flag <= 1'b0;
         overrun_flag     <= 1'b0;
         rx_data          <= {DW{1'b0}};
         rx_id_bit        <= 1'b0;
      end
      else
      begin
         // Clears come first, so a frame event below overrides them in the same cycle.
         if (rx_full_clr)
         begin
            rx_full_flag <= 1'b0;
         end
         if (err_clr)
         begin
            framing_err_flag <= 1'b0;
            overrun_flag     <= 1'b0;
         end
         if (pass)
         begin
            if (rx_full_flag && !rx_full_clr)
            begin
               overrun_flag <= 1'b1; // Old data kept when unread.
            end
            else if (!stop_ok_q)
            begin
               framing_err_flag <= 1'b1; // Full flag is clear or being cleared here.
            end
            else
            begin
               rx_full_flag <= 1'b1;
               rx_data      <= sh_q[DW-1:0];
               rx_id_bit    <= sh_q[DW];
            end
         end
      end
   end

   // Requests follow the flags, which the gate already held off.
   assign rx_full_irq  = rx_full_flag;
   assign rx_error_irq = framing_err_flag | overrun_flag;

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter.
   srtx_tx
   #(
      .DW      (DW),
      .BIT_CYC (BIT_CYC)
   )
   u_tx
   (
      .clk       (clk),
      .rstn      (rstn),
      .tx_en     (tx_en),
      .tx_valid  (tx_valid),
      .tx_data   (tx_data),
      .tx_id_bit (frame_id_bit),
      .tx_ready  (tx_ready),
      .tx_end    (tx_end_irq),
      .txd       (txd)
   );

endmodule

/* File: srtx_top_assertions.sv */
`timescale 1ns/1ps
// Checks request ties, gate clearing and transmitter idling at the top ports.
module srtx_chk
(
   // Clock and reset.
   input wire clk,
   input wire rstn,
   // Watched signals.
   input wire gate_wr,
   input wire gate_wdata,
   input wire rx_en,
   input wire tx_en,
   input wire mp_gate_enable,
   input wire rx_full_flag,
   input wire framing_err_flag,
   input wire overrun_flag,
   input wire rx_full_irq,
   input wire rx_error_irq,
   input wire tx_valid,
   input wire tx_ready,
   input wire tx_end_irq,
   input wire txd
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Requests follow their flags, so a suppressed flag also holds back its request.
   a_full_irq_tie: assert property (rx_full_irq == rx_full_flag)
      else $error("full request differs from flag");
   a_err_irq_tie: assert property (rx_error_irq == (framing_err_flag | overrun_flag))
      else $error("error request differs from flags");
   a_gate_sw_clear: assert property (gate_wr && !gate_wdata |=> !mp_gate_enable)
      else $error("gate write of zero ignored");
   a_gate_full_hold: assert property ($rose(rx_full_flag) && $past(mp_gate_enable) |-> !mp_gate_enable)
      else $error("full flag set while gated");
   a_gate_err_hold: assert property ($rose(rx_error_irq) && $past(mp_gate_enable) |-> !mp_gate_enable)
      else $error("error flag set while gated");
   a_gate_auto_clear: assert property ($fell(mp_gate_enable) && !$past(gate_wr) |-> rx_full_flag || rx_error_irq)
      else $error("gate cleared without frame");
   // The receiver decides one cycle before the flag lands, so look two samples back.
   a_rx_off_quiet: assert property ($rose(rx_full_flag) |-> $past(rx_en, 2))
      else $error("frame taken while receiver off");
   a_tx_off_idle: assert property (!tx_en && !$past(tx_en) |-> txd && !tx_ready)
      else $error("transmitter active while off");
   a_tx_start_bit: assert property (tx_valid && tx_ready ##1 tx_en |-> !txd && !tx_ready)
      else $error("no start bit after request");
   a_tx_end_pulse: assert property (tx_end_irq |=> !tx_end_irq)
      else $error("end pulse too long");
endmodule

/* File: srtx_tx.v */
`timescale 1ns/1ps
`include "srtx_defines.vh"

// Transmitter: sends start, data, frame id bit and stop, only while enabled.
module srtx_tx
#(
   parameter DW      = `SRTX_DATA_BITS,
   parameter [15:0] BIT_CYC = `SRTX_BIT_CYCLES
)
(
   // Clock and reset.
   input  wire          clk,
   input  wire          rstn,
   // Control.
   input  wire          tx_en,
   // Data in.
   input  wire          tx_valid,
   input  wire [DW-1:0] tx_data,
   input  wire          tx_id_bit,
   output wire          tx_ready,
   output reg           tx_end,
   // Line.
   output reg           txd
);

   reg  [1:0]    st_q;
   reg  [15:0]   cnt_q;
   reg  [DW+1:0] sh_q;
   reg  [3:0]    bit_q;

   // Handshake is open only while idle and enabled.
   assign tx_ready = tx_en && (st_q == `SRTX_ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Frame shifter; a cleared enable parks the line idle at once.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q   <= `SRTX_ST_IDLE;
         cnt_q  <= 16'h0000;
         sh_q   <= {(DW+2){1'b1}};
         bit_q  <= 4'h0;
         txd    <= 1'b1;
         tx_end <= 1'b0;
      end
      else
      begin
         tx_end <= 1'b0;
         if (!tx_en)
         begin
            st_q <= `SRTX_ST_IDLE;
            txd  <= 1'b1;
         end
         else if (st_q == `SRTX_ST_IDLE)
         begin
            if (tx_valid)
            begin
               sh_q  <= {1'b1, tx_id_bit, tx_data};
               txd   <= 1'b0;
               cnt_q <= 16'h0000;
               bit_q <= 4'h0;
               st_q  <= `SRTX_ST_DATA;
            end
         end
         else if (cnt_q == BIT_CYC - 16'h0001)
         begin
            cnt_q <= 16'h0000;
            txd   <= sh_q[0];
            sh_q  <= {1'b1, sh_q[DW+1:1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q == DW + 2)
            begin
               st_q   <= `SRTX_ST_IDLE;
               tx_end <= 1'b1;
               txd    <= 1'b1;
            end
         end
         else
         begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

endmodule

/* File: test_srtx_top.sv */
`timescale 1ns/1ps
// Bench for gate, receive enable and transmit enable behaviour.
module test_srtx_top;
   reg        clk = 0, rstn = 0, gate_wr = 0, gate_wdata = 0, rx_en = 0, tx_en = 0;
   reg        rx_full_clr = 0, err_clr = 0, tx_valid = 0, frame_id_bit = 0;
   reg  [7:0] tx_data = 8'h00;
   wire [7:0] rx_data;
   wire       rxd, rx_id_bit, mp_gate_enable, rx_full_flag, framing_err_flag, overrun_flag;
   wire       rx_full_irq, rx_error_irq, tx_ready, tx_end_irq, txd;
   integer    miscompares = 0, checks = 0, k, n;
   reg [10:0] f;
   always #10 clk = ~clk;
   srtx_top #(.BIT_CYC(16'h0004)) DUT (.clk(clk), .rstn(rstn), .gate_wr(gate_wr),
      .gate_wdata(gate_wdata), .rx_en(rx_en), .tx_en(tx_en), .rx_full_clr(rx_full_clr),
      .err_clr(err_clr), .rxd(rxd), .rx_data(rx_data), .rx_id_bit(rx_id_bit),
      .mp_gate_enable(mp_gate_enable), .rx_full_flag(rx_full_flag),
      .framing_err_flag(framing_err_flag), .overrun_flag(overrun_flag),
      .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .tx_valid(tx_valid),
      .tx_data(tx_data), .frame_id_bit(frame_id_bit), .tx_ready(tx_ready),
      .tx_end_irq(tx_end_irq), .txd(txd));
   srtx_station #(.BC(4)) P (.clk(clk), .line(rxd));
   // Compares one value; flags are packed as full, framing, overrun, full req, error req.
   task cmp(input [7:0] got, input [7:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp)
         begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task flags(input [4:0] exp);
      cmp({rx_full_flag, framing_err_flag, overrun_flag, rx_full_irq, rx_error_irq}, exp);
   endtask
   task gate(input v);
      begin
         @(negedge clk) {gate_wr, gate_wdata} = {1'b1, v};
         @(negedge clk) gate_wr = 1'b0;
      end
   endtask
   task clear;
      begin
         @(negedge clk) {rx_full_clr, err_clr} = 2'b11;
         @(negedge clk) {rx_full_clr, err_clr} = 2'b00;
      end
   endtask
   task stop_test;
      begin
         if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // Limit well above the length of the sequence.
   initial
   begin
      #100000 miscompares = miscompares + 1;
      stop_test;
   end
   // Main sequence.
   initial
   begin
      repeat (20) @(posedge clk);
      @(negedge clk) {rstn, rx_en} = 2'b11;
      cmp(mp_gate_enable, 0);
      // Open gate: a plain frame fills the flags, a second one overruns.
      P.send(8'ha5, 0, 1);
      flags(5'b10010);
      cmp(rx_data, 8'ha5);
      cmp(rx_id_bit, 0);
      P.send(8'h5a, 0, 1);
      flags(5'b10111);
      cmp(rx_data, 8'ha5);
      clear;
      flags(5'b00000);
      // Closed gate: id-bit-0 frames, good or bad, change nothing.
      gate(1);
      P.send(8'h11, 0, 1);
      P.send(8'h22, 0, 0);
      flags(5'b00000);
      cmp(mp_gate_enable, 1);
      P.send(8'h3c, 1, 1);
      cmp(mp_gate_enable, 0);
      flags(5'b10010);
      cmp(rx_data, 8'h3c);
      cmp(rx_id_bit, 1);
      clear;
      gate(1);
      gate(0);
      cmp(mp_gate_enable, 0);
      P.send(8'h44, 0, 1);
      flags(5'b10010);
      cmp(rx_data, 8'h44);
      cmp(rx_id_bit, 0);
      // Closed gate with unread data: a dropped frame must not overrun.
      gate(1);
      P.send(8'h55, 0, 1);
      flags(5'b10010);
      cmp(rx_data, 8'h44);
      clear;
      // Receiver off: an id-bit-1 frame neither lands nor clears the gate.
      rx_en = 0;
      P.send(8'h66, 1, 1);
      flags(5'b00000);
      cmp(mp_gate_enable, 1);
      rx_en = 1;
      gate(0);
      P.send(8'h77, 0, 0);
      flags(5'b01001);
      // Transmitter off: a pending request is not taken and the line stays idle.
      {tx_valid, tx_data, frame_id_bit} = {1'b1, 8'h96, 1'b1};
      repeat (8) @(negedge clk);
      cmp({tx_ready, txd}, 2'b01);
      tx_en = 1;
      f = {1'b1, frame_id_bit, tx_data, 1'b0};
      @(negedge clk) tx_valid = 0;
      cmp(tx_ready, 0);
      for (k = 0; k < 11; k = k + 1)
      begin
         cmp(txd, f[k]);
         if (k < 10)
            repeat (4) @(negedge clk);
      end
      // The end pulse follows one full stop bit of four clocks.
      n = 0;
      while (tx_end_irq !== 1'b1 && n < 10)
      begin
         @(negedge clk);
         n = n + 1;
      end
      cmp(n, 4);
      // A second frame is cut while its first data bit, a zero, is on the line.
      tx_valid = 1;
      repeat (6) @(negedge clk);
      tx_en = 0;
      repeat (2) @(negedge clk);
      cmp({tx_ready, txd}, 2'b01);
      stop_test;
   end
endmodule
bind srtx_top srtx_chk u_chk (.clk(clk), .rstn(rstn), .gate_wr(gate_wr),
   .gate_wdata(gate_wdata), .rx_en(rx_en), .tx_en(tx_en), .mp_gate_enable(mp_gate_enable),
   .rx_full_flag(rx_full_flag), .framing_err_flag(framing_err_flag),
   .overrun_flag(overrun_flag), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_end_irq(tx_end_irq), .txd(txd));
